// ### uart_baud_timer.sv
// baud timer: prescaler and 16-bit reload counter
// assumes the core clock drives it; one output pulse per overflow
`timescale 1ns/1ps
module uart_baud_timer
(
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        srst_in,
  // settings
  input  wire logic [1:0]  baud_prescale_sel_in,
  input  wire logic [15:0] baud_reload_in,
  // overflow pulse, two per bit time
  output logic             half_tick_out
);
  import uart_pkg::*;

  logic [5:0]  pre_cnt_reg;
  logic [15:0] timer_reg;
  logic        half_tick_reg;
  wire         pre_tick = (pre_cnt_reg >= PRESCALE_DIV[baud_prescale_sel_in] - 6'd1);
  wire         overflow = pre_tick && (timer_reg == TIMER_TOP);

  // ----------------------------------------
  // counters
  // ----------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      pre_cnt_reg   <= 6'h00;
      timer_reg     <= RELOAD_RESET;
      half_tick_reg <= 1'b0;
    end
    else
    begin
      pre_cnt_reg   <= pre_tick ? 6'h00 : pre_cnt_reg + 6'd1;
      if (pre_tick)
        timer_reg <= overflow ? baud_reload_in : timer_reg + 16'd1;
      half_tick_reg <= overflow;
    end
  end

  assign half_tick_out = half_tick_reg;

endmodule

// ### uart_fifo_multiproc_serial_bench.sv
// self-checking bench for the serial port
// assumes uart_pkg and the remote node model compile first
`timescale 1ns/1ps
module uart_fifo_multiproc_serial_bench;
  import uart_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdat = 8'h00;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [7:0]  rdat;
  logic        rx_line;
  logic        tx_line;
  logic [3:0]  nbits = 4'h9;
  logic        got;
  logic [11:0] frame;
  logic [18:0] rq[$];
  logic [11:0] fq[$];
  logic [18:0] note;
  logic        rd_pend = 1'b0;
  logic [7:0]  d[4];
  logic [11:0] b;
  logic [7:0]  fmts[12] = '{8'h06, 8'h00, 8'h01, 8'h03, 8'h05, 8'h0e, 8'h1e, 8'h2e, 8'h3e, 8'h46, 8'h4f, 8'hc4};
  int          bad_count = 0;
  int          num_checks = 0;
  int          seen = 0;
  int          sent = 0;
  always #12.5 clk = ~clk;
  uart_serial_port dut_u
  (
    .clk_sys_in         (clk),
    .srst_in            (srst),
    .reg_addr_in        (addr),
    .reg_wdata_in       (wdat),
    .reg_wr_in          (wr_s),
    .reg_rd_in          (rd_s),
    .reg_rdata_out      (rdat),
    .serial_in_pin_in   (rx_line),
    .serial_out_pin_out (tx_line)
  );
  uart_remote_node #(.BIT_CLKS(8)) rmt_u
  (
    .clk_sys_in (clk),
    .line_in    (tx_line),
    .line_out   (rx_line),
    .nbits_in   (nbits),
    .got_out    (got),
    .frame_out  (frame)
  );
  // ----
  // compares and bus cycles
  // ----
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk12(input logic [11:0] e, input logic [11:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch frame expected %h seen %h", e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdat <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    rq.push_back({a, m, e});
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
  endtask
  always @(negedge clk)
  begin
    if (rd_pend)
    begin
      note = rq.pop_front();
      chk8($sformatf("reg%0d", note[18:16]), note[7:0], rdat & note[15:8]);
    end
    rd_pend = rd_s;
  end
  always @(posedge got)
  begin
    chk12(fq.pop_front(), frame);
    seen++;
  end
  task automatic wait_tx;
    for (int i = 0; seen < sent; i++)
    begin
      @(posedge clk);
      if (i > 2000)
      begin
        bad_count++;
        wrap_up();
      end
    end
    repeat (8) @(posedge clk);
    chk8("tx_idle", 8'h01, {7'h00, tx_line});
  endtask
  // expected wire bits after the start bit, and their count
  function automatic int build(input logic [7:0] f, input logic [7:0] v, input logic t, output logic [11:0] bits);
    int  k;
    logic x;
    k = int'(f[FMT_LEN+:2]) + 5;
    bits = '1;
    for (int i = 0; i < k; i++)
      bits[i] = v[i];
    x = ^(v & (8'hff >> (8 - k)));
    case (f[FMT_PTYPE+:2])
      PAR_ODD:   x = ~x;
      PAR_MARK:  x = 1'b1;
      PAR_SPACE: x = 1'b0;
      default:   x = x;
    endcase
    // without parity the extra bit carries the tx extra bit control
    if (!f[FMT_PE])
      x = t;
    if (f[FMT_PE] || f[FMT_XBE])
      bits[k] = x;
    return k + int'(f[FMT_PE] || f[FMT_XBE]) + ((f[FMT_STOP2] && k > 5) ? 2 : 1);
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial
  begin
    void'($urandom(27927));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd(ADDR_CONTROL, 8'hff, 8'h20);
    rd(ADDR_FORMAT, 8'hff, FORMAT_RESET);
    rd(3'h6, 8'hff, 8'h00);
    wr(ADDR_RLD_LO, 8'hfc);
    wr(ADDR_RLD_HI, 8'hff);
    // old reload of zero must run out before the new pair applies
    repeat (66000) @(posedge clk);
    $display("test reset done");
    wr(ADDR_CONTROL, 8'h18);
    foreach (fmts[i])
    begin
      d[0] = 8'($urandom);
      // tx extra bit follows bit 1 of the index, so both values go out
      d[1] = {4'h1, 1'(i >> 1), 3'h0};
      wr(ADDR_CONTROL, d[1]);
      nbits <= 4'(build(fmts[i], d[0], d[1][CTL_TBX], b));
      fq.push_back(b);
      sent++;
      // divide by 4 with a reload of all ones keeps the 8-clock bit
      if (i == 11)
      begin
        wr(ADDR_BAUD, 8'h01);
        wr(ADDR_RLD_LO, 8'hff);
      end
      wr(ADDR_FORMAT, fmts[i]);
      wr(ADDR_BUFFER, d[0]);
      wait_tx();
      rd(ADDR_CONTROL, 8'h02, 8'h02);
    end
    rd(ADDR_BAUD, 8'hff, 8'h01);
    $display("test transmit done");
    wr(ADDR_FORMAT, 8'h06);
    wr(ADDR_CONTROL, 8'h00);
    rmt_u.send(12'hf5a, 9);
    rd(ADDR_CONTROL, 8'h01, 8'h00);
    wr(ADDR_CONTROL, 8'h10);
    for (int i = 0; i < 4; i++)
    begin
      d[i] = 8'($urandom);
      rmt_u.send({4'hf, d[i]}, 9);
    end
    repeat (4) @(posedge clk);
    rd(ADDR_CONTROL, 8'h81, 8'h81);
    wr(ADDR_CONTROL, 8'h10);
    rd(ADDR_CONTROL, 8'h81, 8'h01);
    rd(ADDR_BUFFER, 8'hff, d[0]);
    rd(ADDR_BUFFER, 8'hff, d[1]);
    wr(ADDR_CONTROL, 8'h10);
    rd(ADDR_CONTROL, 8'h01, 8'h00);
    rd(ADDR_BUFFER, 8'hff, d[2]);
    rmt_u.send({4'he, d[3]}, 9);
    repeat (4) @(posedge clk);
    rd(ADDR_CONTROL, 8'h01, 8'h00);
    $display("test receive done");
    wr(ADDR_FORMAT, 8'h1e);
    // parity bit 0 is wrong for even parity over 0x01; stop bit high
    rmt_u.send({4'h2, 8'h01}, 10);
    repeat (4) @(posedge clk);
    rd(ADDR_CONTROL, 8'h45, 8'h45);
    rd(ADDR_BUFFER, 8'hff, 8'h01);
    wr(ADDR_CONTROL, 8'h10);
    wr(ADDR_FORMAT, 8'hc6);
    rmt_u.send({4'he, d[3]}, 10);
    repeat (4) @(posedge clk);
    rd(ADDR_CONTROL, 8'h05, 8'h00);
    rd(ADDR_BUFFER, 8'hff, d[3]);
    rmt_u.send({4'hf, d[1]}, 10);
    repeat (4) @(posedge clk);
    rd(ADDR_CONTROL, 8'h05, 8'h05);
    rd(ADDR_BUFFER, 8'hff, d[1]);
    $display("test parity and multidrop done");
    wrap_up();
  end
endmodule

// ### uart_pkg.sv
// constants shared by the serial port and its baud timer
// assumes a byte-wide register port with three address bits
package uart_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [2:0] ADDR_BUFFER  = 3'h0;
  localparam logic [2:0] ADDR_CONTROL = 3'h1;
  localparam logic [2:0] ADDR_FORMAT  = 3'h2;
  localparam logic [2:0] ADDR_BAUD    = 3'h3;
  localparam logic [2:0] ADDR_RLD_LO  = 3'h4;
  localparam logic [2:0] ADDR_RLD_HI  = 3'h5;

  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int CTL_OVR  = 7;
  localparam int CTL_PERR = 6;
  localparam int CTL_THRE = 5;
  localparam int CTL_REN  = 4;
  localparam int CTL_TBX  = 3;
  localparam int CTL_RBX  = 2;
  localparam int CTL_TI   = 1;
  localparam int CTL_RI   = 0;

  // ----------------------------------------
  // format field positions
  // ----------------------------------------
  localparam int FMT_MCE   = 7;
  localparam int FMT_XBE   = 6;
  localparam int FMT_PTYPE = 4;
  localparam int FMT_PE    = 3;
  localparam int FMT_LEN   = 1;
  localparam int FMT_STOP2 = 0;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0]  FORMAT_RESET = 8'h06;
  localparam logic [1:0]  PRESCALE_RESET = 2'h0;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;

  // ----------------------------------------
  // parity types, timer figures and fifo depth
  // ----------------------------------------
  localparam logic [1:0] PAR_ODD   = 2'h0;
  localparam logic [1:0] PAR_EVEN  = 2'h1;
  localparam logic [1:0] PAR_MARK  = 2'h2;
  localparam logic [1:0] PAR_SPACE = 2'h3;
  localparam logic [5:0] PRESCALE_DIV [4] = '{6'd1, 6'd4, 6'd12, 6'd48};
  localparam logic [15:0] TIMER_TOP = 16'hffff;
  localparam int FIFO_DEPTH = 3;

endpackage

// ### uart_remote_node.sv
// remote serial node on the far side of the port's line pins
// assumes bits of BIT_CLKS core clocks and an idle-high line
`timescale 1ns/1ps
module uart_remote_node
#(
  parameter int BIT_CLKS = 8
)
(
  // clock
  input  wire logic        clk_sys_in,
  // serial lines
  input  wire logic        line_in,
  output logic             line_out,
  // capture length and result
  input  wire logic [3:0]  nbits_in,
  output logic             got_out,
  output logic [11:0]      frame_out
);
  // ----
  // sender
  // ----
  initial line_out = 1'b1;
  initial got_out = 1'b0;
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = -1; i < n; i++)
    begin
      line_out <= (i < 0) ? 1'b0 : bits[i];
      repeat (BIT_CLKS) @(posedge clk_sys_in);
    end
    line_out <= 1'b1;
    @(posedge clk_sys_in);
  endtask
  // ----
  // capture
  // ----
  // quarter-bit offset tolerates a start bit up to three quarters of a bit short
  always
  begin
    @(negedge line_in);
    frame_out = '1;
    repeat (BIT_CLKS / 4) @(posedge clk_sys_in);
    for (int i = 0; i < nbits_in; i++)
    begin
      repeat (BIT_CLKS) @(posedge clk_sys_in);
      frame_out[i] = line_in;
    end
    got_out = 1'b1;
    @(posedge clk_sys_in);
    got_out = 1'b0;
  end
endmodule

// ### uart_serial_port.sv
// full-duplex serial port with 3-byte receive fifo
// assumes a byte register port, synchronous inputs and one clock
`timescale 1ns/1ps

module uart_serial_port
(
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       srst_in,
  // register port
  input  wire logic [2:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // serial line
  input  wire logic       serial_in_pin_in,
  output logic            serial_out_pin_out
);
  import uart_pkg::*;

  typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_EXTRA, T_STOP} tx_state_type;
  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_EXTRA, R_STOP} rx_state_type;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]  format_reg;
  logic [1:0]  baud_prescale_sel;
  logic [7:0]  baud_reload_low;
  logic [7:0]  baud_reload_high;
  logic        rx_overrun_flag, parity_error_flag, rx_enable, tx_extra_bit;
  logic        tx_done_flag, rx_done_flag, thre_reg;
  logic [7:0]  tx_hold_reg, rdata_reg;
  logic        half_tick;

  wire multiproc_enable = format_reg[FMT_MCE];
  wire extra_bit_enable = format_reg[FMT_XBE];
  wire [1:0] parity_type_sel = format_reg[FMT_PTYPE +: 2];
  wire parity_enable = format_reg[FMT_PE];
  wire [1:0] len_sel = format_reg[FMT_LEN +: 2];
  wire [2:0] last_bit = {1'b1, len_sel};
  wire two_stops = format_reg[FMT_STOP2] && (len_sel != 2'h0);
  wire xbit_on = extra_bit_enable && !parity_enable;
  wire frame_extra = parity_enable || extra_bit_enable;

  wire wr_buf = reg_wr_in && (reg_addr_in == ADDR_BUFFER);
  wire wr_ctl = reg_wr_in && (reg_addr_in == ADDR_CONTROL);
  wire rd_buf = reg_rd_in && (reg_addr_in == ADDR_BUFFER);

  // parity bit that makes the frame match the selected type
  function automatic logic parity_of(input logic [7:0] d, input logic [1:0] sel);
    logic ones;
    ones = ^d;
    case (sel)
      PAR_ODD:   parity_of = ~ones;
      PAR_EVEN:  parity_of = ones;
      PAR_MARK:  parity_of = 1'b1;
      default:   parity_of = 1'b0;
    endcase
  endfunction

  uart_baud_timer u_baud
  (
    .clk_sys_in           (clk_sys_in),
    .srst_in              (srst_in),
    .baud_prescale_sel_in (baud_prescale_sel),
    .baud_reload_in       ({baud_reload_high, baud_reload_low}),
    .half_tick_out        (half_tick)
  );

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  tx_state_type tx_state;
  logic [7:0]   tx_shift_reg;
  logic [2:0]   tx_cnt_reg;
  logic         tx_phase_reg, tx_par_reg, tx_stop2_reg, tx_out_reg;
  wire          tx_bit_end = half_tick && tx_phase_reg;
  wire [7:0]    tx_mask = 8'hff >> (3'd7 - last_bit);
  wire          tx_load = (tx_state == T_IDLE) && !thre_reg && half_tick;
  wire          tx_stop_enter = (tx_state == T_EXTRA || (tx_state == T_DATA && tx_cnt_reg == last_bit
                                 && !frame_extra)) && tx_bit_end;
  wire          tx_extra_val = parity_enable ? tx_par_reg : tx_extra_bit;
  logic         tx_line;

  always_comb
  begin
    case (tx_state)
      T_START: tx_line = 1'b0;
      T_DATA:  tx_line = tx_shift_reg[0];
      T_EXTRA: tx_line = tx_extra_val;
      default: tx_line = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      tx_state     <= T_IDLE;
      tx_shift_reg <= 8'h00;
      tx_cnt_reg   <= 3'h0;
      tx_phase_reg <= 1'b0;
      tx_par_reg   <= 1'b0;
      tx_stop2_reg <= 1'b0;
      tx_out_reg   <= 1'b1;
    end
    else
    begin
      tx_out_reg <= tx_line;
      if (tx_state != T_IDLE && half_tick)
        tx_phase_reg <= !tx_phase_reg;
      case (tx_state)
        T_IDLE:
          if (tx_load)
          begin
            tx_state     <= T_START;
            tx_shift_reg <= tx_hold_reg;
            tx_par_reg   <= parity_of(tx_hold_reg & tx_mask, parity_type_sel);
            tx_phase_reg <= 1'b0;
          end
        T_START:
          if (tx_bit_end)
          begin
            tx_state   <= T_DATA;
            tx_cnt_reg <= 3'h0;
          end
        T_DATA:
          if (tx_bit_end)
          begin
            tx_shift_reg <= tx_shift_reg >> 1;
            tx_cnt_reg   <= tx_cnt_reg + 3'd1;
            if (tx_cnt_reg == last_bit)
              tx_state <= frame_extra ? T_EXTRA : T_STOP;
            tx_stop2_reg <= 1'b0;
          end
        T_EXTRA:
          if (tx_bit_end)
            tx_state <= T_STOP;
        T_STOP:
          if (tx_bit_end)
          begin
            if (two_stops && !tx_stop2_reg)
              tx_stop2_reg <= 1'b1;
            else
              tx_state <= T_IDLE;
          end
        default: tx_state <= T_IDLE;
      endcase
    end
  end

  assign serial_out_pin_out = tx_out_reg;

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  rx_state_type rx_state;
  logic [7:0]   rx_shift_reg;
  logic [2:0]   rx_cnt_reg;
  logic         rx_prev_reg, rx_phase_reg, rx_extra_reg, rx_second_reg, rx_stop1_reg;
  wire          rx_in = serial_in_pin_in;
  wire          rx_sample = half_tick && rx_phase_reg;
  wire          rx_fall = rx_enable && rx_prev_reg && !rx_in;
  wire          frame_done = (rx_state == R_STOP) && rx_sample && (!two_stops || rx_second_reg);
  wire          stop_ok = rx_in && (!rx_second_reg || rx_stop1_reg);
  wire [7:0]    rx_data = rx_shift_reg >> (3'd7 - last_bit);
  wire          first_stop = rx_second_reg ? rx_stop1_reg : rx_in;
  wire          rx_bit9 = xbit_on ? rx_extra_reg : first_stop;
  wire          rx_par_bad = parity_enable && (rx_in != parity_of(rx_data, parity_type_sel));

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      rx_state      <= R_IDLE;
      rx_shift_reg  <= 8'h00;
      rx_cnt_reg    <= 3'h0;
      rx_prev_reg   <= 1'b1;
      rx_phase_reg  <= 1'b0;
      rx_extra_reg  <= 1'b0;
      rx_second_reg <= 1'b0;
      rx_stop1_reg  <= 1'b0;
    end
    else
    begin
      rx_prev_reg <= rx_in;
      if (rx_state != R_IDLE && half_tick)
        rx_phase_reg <= !rx_phase_reg;
      case (rx_state)
        R_IDLE:
          if (rx_fall)
          begin
            rx_state     <= R_START;
            rx_phase_reg <= 1'b1;
          end
        R_START:
          if (rx_sample)
          begin
            rx_state   <= rx_in ? R_IDLE : R_DATA;
            rx_cnt_reg <= 3'h0;
          end
        R_DATA:
          if (rx_sample)
          begin
            rx_shift_reg <= {rx_in, rx_shift_reg[7:1]};
            rx_cnt_reg   <= rx_cnt_reg + 3'd1;
            if (rx_cnt_reg == last_bit)
              rx_state <= frame_extra ? R_EXTRA : R_STOP;
            rx_second_reg <= 1'b0;
          end
        R_EXTRA:
          if (rx_sample)
          begin
            rx_extra_reg <= rx_in;
            rx_state     <= R_STOP;
          end
        R_STOP:
          if (frame_done)
            rx_state <= R_IDLE;
          else if (rx_sample)
          begin
            rx_second_reg <= 1'b1;
            rx_stop1_reg  <= rx_in;
          end
        default: rx_state <= R_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // receive fifo
  // ----------------------------------------
  logic [8:0] fifo_mem_reg [FIFO_DEPTH];
  logic [1:0] wr_ptr_reg, rd_ptr_reg, count_reg;
  wire        fifo_full = (count_reg == 2'(FIFO_DEPTH));
  wire        store = frame_done && stop_ok && !fifo_full;
  wire        pop = rd_buf && (count_reg != 2'h0);
  wire [8:0]  head = fifo_mem_reg[rd_ptr_reg];
  wire [1:0]  wr_ptr_inc = (wr_ptr_reg == 2'(FIFO_DEPTH - 1)) ? 2'h0 : wr_ptr_reg + 2'd1;
  wire [1:0]  rd_ptr_inc = (rd_ptr_reg == 2'(FIFO_DEPTH - 1)) ? 2'h0 : rd_ptr_reg + 2'd1;

  genvar gi;
  generate
    for (gi = 0; gi < FIFO_DEPTH; gi++)
    begin : g_entry
      always_ff @(posedge clk_sys_in)
      begin
        if (srst_in)
          fifo_mem_reg[gi] <= 9'h000;
        else if (store && wr_ptr_reg == 2'(gi))
          fifo_mem_reg[gi] <= {rx_bit9, rx_data};
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      wr_ptr_reg <= 2'h0;
      rd_ptr_reg <= 2'h0;
      count_reg  <= 2'h0;
    end
    else
    begin
      if (store)
        wr_ptr_reg <= wr_ptr_inc;
      if (pop)
        rd_ptr_reg <= rd_ptr_inc;
      count_reg <= count_reg + 2'(store) - 2'(pop);
    end
  end

  // ----------------------------------------
  // flags and settings
  // ----------------------------------------
  // hardware set wins over a software write in the same cycle
  wire ri_set = store && (!multiproc_enable || rx_bit9);
  wire ri_clr_ok = (count_reg <= 2'h1);
  wire ti_set = tx_stop_enter;
  wire perr_set = (rx_state == R_EXTRA) && rx_sample && rx_par_bad;
  wire ovr_set = frame_done && fifo_full;

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      rx_overrun_flag   <= 1'b0;
      parity_error_flag <= 1'b0;
      rx_enable         <= 1'b0;
      tx_extra_bit      <= 1'b0;
      tx_done_flag      <= 1'b0;
      rx_done_flag      <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
      begin
        rx_overrun_flag   <= reg_wdata_in[CTL_OVR];
        parity_error_flag <= reg_wdata_in[CTL_PERR];
        rx_enable         <= reg_wdata_in[CTL_REN];
        tx_extra_bit      <= reg_wdata_in[CTL_TBX];
        tx_done_flag      <= reg_wdata_in[CTL_TI];
        if (reg_wdata_in[CTL_RI] || ri_clr_ok)
          rx_done_flag <= reg_wdata_in[CTL_RI];
      end
      if (ovr_set)
        rx_overrun_flag <= 1'b1;
      if (perr_set)
        parity_error_flag <= 1'b1;
      if (ti_set)
        tx_done_flag <= 1'b1;
      if (ri_set)
        rx_done_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      format_reg        <= FORMAT_RESET;
      baud_prescale_sel <= PRESCALE_RESET;
      baud_reload_low   <= RELOAD_RESET[7:0];
      baud_reload_high  <= RELOAD_RESET[15:8];
      tx_hold_reg       <= 8'h00;
      thre_reg          <= 1'b1;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == ADDR_FORMAT)
        format_reg <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == ADDR_BAUD)
        baud_prescale_sel <= reg_wdata_in[1:0];
      if (reg_wr_in && reg_addr_in == ADDR_RLD_LO)
        baud_reload_low <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == ADDR_RLD_HI)
        baud_reload_high <= reg_wdata_in;
      if (wr_buf)
      begin
        tx_hold_reg <= reg_wdata_in;
        thre_reg    <= 1'b0;
      end
      else if (tx_load)
        thre_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  wire [7:0] ctl_view = {rx_overrun_flag, parity_error_flag, thre_reg, rx_enable,
                         tx_extra_bit, head[8], tx_done_flag, rx_done_flag};
  logic [7:0] rd_mux;

  always_comb
  begin
    case (reg_addr_in)
      ADDR_BUFFER:  rd_mux = head[7:0];
      ADDR_CONTROL: rd_mux = ctl_view;
      ADDR_FORMAT:  rd_mux = format_reg;
      ADDR_BAUD:    rd_mux = {6'h00, baud_prescale_sel};
      ADDR_RLD_LO:  rd_mux = baud_reload_low;
      ADDR_RLD_HI:  rd_mux = baud_reload_high;
      default:      rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
      rdata_reg <= 8'h00;
    else if (reg_rd_in)
      rdata_reg <= rd_mux;
  end

  assign reg_rdata_out = rdata_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  sequence s_buf_write;
    wr_buf && (tx_state == T_IDLE) && thre_reg;
  endsequence
  sequence s_stop_begins;
    (tx_state != T_STOP) ##1 (tx_state == T_STOP);
  endsequence

  a_idle_line_high: assert property ((tx_state == T_IDLE) |=> serial_out_pin_out)
    else $error("tx line low while idle");
  a_start_bit_low: assert property ((tx_state == T_START) |=> !serial_out_pin_out)
    else $error("start bit not low");
  a_tx_starts: assert property (s_buf_write |=> !thre_reg)
    else $error("buffer write did not load transmitter");
  a_tx_done_set: assert property (s_stop_begins |-> tx_done_flag)
    else $error("tx done not set at stop time");
  a_parity_out: assert property ((tx_state == T_EXTRA && parity_enable)
    |=> serial_out_pin_out == $past(tx_par_reg))
    else $error("wrong parity bit sent");
  a_rx_gated: assert property ((!rx_enable && rx_state == R_IDLE) |=> rx_state == R_IDLE)
    else $error("receiver started while disabled");
  a_overrun_set: assert property ((frame_done && fifo_full) |=> rx_overrun_flag && count_reg != 2'h0)
    else $error("overrun not flagged");
  a_bad_stop_drop: assert property ((frame_done && !stop_ok && !pop) |=> $stable(count_reg))
    else $error("frame with low stop stored");
  a_pop_count: assert property ((pop && !store) |=> count_reg == $past(count_reg) - 2'd1)
    else $error("buffer read did not free an entry");
  a_ri_holds: assert property ((rx_done_flag && wr_ctl && !reg_wdata_in[CTL_RI] && count_reg > 2'h1)
    |=> rx_done_flag)
    else $error("rx done cleared with bytes waiting");

endmodule
